/* File: verilog/brl_core.sv */
`timescale 1ns/1ps
`default_nettype none
module brl_core (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_b_in,
  input  wire brl_pkg::brl_rx_t     rx_in,
  input  wire logic                 rate_ok_in,
  input  wire logic                 rd_prot_in,
  input  wire logic                 wr_prot_in,
  input  wire logic [95:0]          password_in,
  input  wire logic                 sum_done_in,
  input  wire logic                 tx_ready_in,
  output logic                      tx_valid_out,
  output logic [7:0]                tx_data_out,
  output brl_pkg::brl_ram_wr_t      ram_wr_out,
  output logic                      jump_out,
  output logic [31:0]               jump_addr_out,
  output logic                      sum_start_out
);
  brl_pkg::brl_state_t state_r;
  brl_pkg::brl_state_t state_nxt;
  logic [3:0]          cmd_hi_r;
  logic [15:0]         cnt_r;
  logic [47:0]         hdr_r;
  logic                pw_bad_r;
  logic [7:0]          cks_sum;
  logic                cks_err;
  logic [7:0]          ck_total;
  logic                tx_load;
  logic [7:0]          tx_byte;
  logic                sum_clr;
  logic                sum_add;
  logic                cnt_clr;
  logic                cnt_inc;
  logic                pw_chk;
  logic                hdr_shift;
  logic                ram_wr;
  logic                jump;
  logic                sum_go;
  logic                cmd_take;

  // Reply to a finished block: error first, then sum, then password
  function automatic logic [7:0] blk_reply(input logic       err,
                                           input logic [7:0] total,
                                           input logic       bad,
                                           input logic [3:0] hi);
    if (err)
      blk_reply = {hi, brl_pkg::NIB_COMM};
    else if (total != brl_pkg::SUM_ZERO)
      blk_reply = {hi, brl_pkg::NIB_CKSUM};
    else if (bad)
      blk_reply = {hi, brl_pkg::NIB_CKSUM};
    else
      blk_reply = brl_pkg::ACK_OK;
  endfunction

  // Password byte selected by its position in the block
  function automatic logic [7:0] pw_byte(input logic [95:0] pw,
                                         input logic [3:0]  idx);
    pw_byte = pw[{idx, 3'b000} +: 8];
  endfunction

  brl_cksum u_cksum (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .clr_in     (sum_clr),
    .add_in     (sum_add),
    .byte_in    (rx_in.data),
    .err_in     (rx_in.err),
    .sum_out    (cks_sum),
    .err_out    (cks_err)
  );

  brl_txhold u_tx (
    .sys_clk_in  (sys_clk_in),
    .rst_b_in    (rst_b_in),
    .load_in     (tx_load),
    .byte_in     (tx_byte),
    .tx_ready_in (tx_ready_in),
    .valid_out   (tx_valid_out),
    .data_out    (tx_data_out)
  );

  // Block sum including the checksum byte now arriving
  assign ck_total = cks_sum + rx_in.data;

  // Sequencer: decides reply byte and next phase per received byte
  always_comb
  begin
    state_nxt = state_r;
    tx_load   = 1'b0;
    tx_byte   = 8'h00;
    sum_clr   = 1'b0;
    sum_add   = 1'b0;
    cnt_clr   = 1'b0;
    cnt_inc   = 1'b0;
    pw_chk    = 1'b0;
    hdr_shift = 1'b0;
    ram_wr    = 1'b0;
    jump      = 1'b0;
    sum_go    = 1'b0;
    cmd_take  = 1'b0;
    case (state_r)
      brl_pkg::ST_SYNC:
        if (rx_in.valid && !rx_in.err && rx_in.data == brl_pkg::SYNC_BYTE && rate_ok_in)
        begin
          tx_load   = 1'b1;
          tx_byte   = brl_pkg::SYNC_BYTE;
          state_nxt = brl_pkg::ST_CMD;
        end
      brl_pkg::ST_CMD:
        if (rx_in.valid)
        begin
          sum_clr = 1'b1;
          cnt_clr = 1'b1;
          tx_load = 1'b1;
          if (rx_in.err)
            tx_byte = {cmd_hi_r, brl_pkg::NIB_COMM};
          else
          begin
            cmd_take = 1'b1;
            case (rx_in.data)
              brl_pkg::CMD_RAM_LOAD:
                if (rd_prot_in || wr_prot_in)
                  tx_byte = {rx_in.data[7:4], brl_pkg::NIB_PROT};
                else
                begin
                  tx_byte   = rx_in.data;
                  state_nxt = brl_pkg::ST_PW;
                end
              brl_pkg::CMD_SUM:
              begin
                tx_byte   = rx_in.data;
                sum_go    = 1'b1;
                state_nxt = brl_pkg::ST_SUM;
              end
              brl_pkg::CMD_INFO,
              brl_pkg::CMD_ERASE,
              brl_pkg::CMD_PROTECT:
                tx_byte = rx_in.data;
              default:
                tx_byte = {rx_in.data[7:4], brl_pkg::NIB_CMD};
            endcase
          end
        end
      brl_pkg::ST_PW:
        if (rx_in.valid)
        begin
          sum_add = 1'b1;
          pw_chk  = 1'b1;
          cnt_inc = 1'b1;
          if (cnt_r == brl_pkg::PW_LEN - 16'h0001)
            state_nxt = brl_pkg::ST_PWCK;
        end
      brl_pkg::ST_PWCK:
        if (rx_in.valid)
        begin
          tx_load   = 1'b1;
          tx_byte   = blk_reply(cks_err | rx_in.err, ck_total, pw_bad_r, cmd_hi_r);
          state_nxt = brl_pkg::ST_CMD;
          if (tx_byte == brl_pkg::ACK_OK)
          begin
            sum_clr   = 1'b1;
            cnt_clr   = 1'b1;
            state_nxt = brl_pkg::ST_HDR;
          end
        end
      brl_pkg::ST_HDR:
        if (rx_in.valid)
        begin
          sum_add   = 1'b1;
          hdr_shift = 1'b1;
          cnt_inc   = 1'b1;
          if (cnt_r == brl_pkg::HDR_LEN - 16'h0001)
            state_nxt = brl_pkg::ST_HDRCK;
        end
      brl_pkg::ST_HDRCK:
        if (rx_in.valid)
        begin
          tx_load   = 1'b1;
          tx_byte   = blk_reply(cks_err | rx_in.err, ck_total, 1'b0, cmd_hi_r);
          state_nxt = brl_pkg::ST_CMD;
          if (tx_byte == brl_pkg::ACK_OK)
          begin
            sum_clr   = 1'b1;
            cnt_clr   = 1'b1;
            state_nxt = (hdr_r[15:0] == 16'h0000) ? brl_pkg::ST_DATACK : brl_pkg::ST_DATA;
          end
        end
      brl_pkg::ST_DATA:
        if (rx_in.valid)
        begin
          sum_add = 1'b1;
          ram_wr  = 1'b1;
          cnt_inc = 1'b1;
          if (cnt_r == hdr_r[15:0] - 16'h0001)
            state_nxt = brl_pkg::ST_DATACK;
        end
      brl_pkg::ST_DATACK:
        if (rx_in.valid)
        begin
          tx_load   = 1'b1;
          tx_byte   = blk_reply(cks_err | rx_in.err, ck_total, 1'b0, cmd_hi_r);
          state_nxt = brl_pkg::ST_CMD;
          if (tx_byte == brl_pkg::ACK_OK)
          begin
            jump      = 1'b1;
            state_nxt = brl_pkg::ST_RUN;
          end
        end
      brl_pkg::ST_SUM:
        if (sum_done_in)
          state_nxt = brl_pkg::ST_CMD;
      brl_pkg::ST_RUN:
        state_nxt = brl_pkg::ST_RUN;
      default:
        state_nxt = brl_pkg::ST_SYNC;
    endcase
  end

  // Phase register
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state_r <= brl_pkg::ST_SYNC;
    else
      state_r <= state_nxt;
  end

  // Upper nibble of the last good command byte, used in error replies
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cmd_hi_r <= brl_pkg::CMD_HI_RST;
    else if (cmd_take)
      cmd_hi_r <= rx_in.data[7:4];
  end

  // Byte position within the current block
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cnt_r <= 16'h0000;
    else if (cnt_clr)
      cnt_r <= 16'h0000;
    else if (cnt_inc)
      cnt_r <= cnt_r + 16'h0001;
  end

  // Sticky password mismatch, dropped with each new command
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pw_bad_r <= 1'b0;
    else if (cmd_take)
      pw_bad_r <= 1'b0;
    else if (pw_chk && rx_in.data != pw_byte(password_in, cnt_r[3:0]))
      pw_bad_r <= 1'b1;
  end

  // Address and length collected MSB first
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      hdr_r <= 48'h000000000000;
    else if (hdr_shift)
      hdr_r <= {hdr_r[39:0], rx_in.data};
  end

  // RAM write port, one byte per data byte at base plus position
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ram_wr_out <= '0;
    else
    begin
      ram_wr_out.we <= ram_wr;
      if (ram_wr)
      begin
        ram_wr_out.addr <= hdr_r[47:16] + {16'h0000, cnt_r};
        ram_wr_out.data <= rx_in.data;
      end
    end
  end

  // Jump and summation start pulses
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      jump_out      <= 1'b0;
      jump_addr_out <= 32'h00000000;
      sum_start_out <= 1'b0;
    end
    else
    begin
      jump_out      <= jump;
      sum_start_out <= sum_go;
      if (jump)
        jump_addr_out <= hdr_r[47:16];
    end
  end

  a_sync_echo: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_r == brl_pkg::ST_SYNC && rx_in.valid && !rate_ok_in |=> !tx_valid_out || $stable(tx_data_out))
    else $error("sync byte answered without rate match");
  a_cmd_err: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_r == brl_pkg::ST_CMD && rx_in.valid && rx_in.err
    |=> tx_valid_out && tx_data_out[3:0] == 4'h8 && state_r == brl_pkg::ST_CMD)
    else $error("command receive error reply wrong");
  a_load_echo: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_r == brl_pkg::ST_CMD && rx_in.valid && !rx_in.err && rx_in.data == 8'h10
    && !rd_prot_in && !wr_prot_in |=> tx_data_out == 8'h10 && state_r == brl_pkg::ST_PW)
    else $error("RAM-load command not echoed");
  a_prot_reply: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_r == brl_pkg::ST_CMD && rx_in.valid && !rx_in.err && rx_in.data == 8'h10
    && (rd_prot_in || wr_prot_in) |=> tx_data_out == 8'h16 && state_r == brl_pkg::ST_CMD)
    else $error("protected RAM-load reply wrong");
  a_bad_cmd: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_r == brl_pkg::ST_CMD && rx_in.valid && !rx_in.err && rx_in.data == 8'h55
    |=> tx_data_out == 8'h51)
    else $error("unknown command reply wrong");
  a_blk_err: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (state_r == brl_pkg::ST_PWCK || state_r == brl_pkg::ST_HDRCK) && rx_in.valid
    && (cks_err || rx_in.err) |=> tx_data_out == 8'h18 && state_r == brl_pkg::ST_CMD)
    else $error("block receive error reply not 18H");
  a_ck_fail: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_r == brl_pkg::ST_HDRCK && rx_in.valid && !cks_err && !rx_in.err
    && ck_total != 8'h00 |=> tx_data_out == 8'h11 && state_r == brl_pkg::ST_CMD)
    else $error("checksum error reply not 11H");
  a_jump_ok: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(jump_out) |-> tx_data_out == 8'h10 && $past(state_r) == brl_pkg::ST_DATACK
    && jump_addr_out == hdr_r[47:16])
    else $error("jump without normal final acknowledge");
  a_sum_start: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    state_r == brl_pkg::ST_CMD && rx_in.valid && !rx_in.err && rx_in.data == 8'h20
    |=> sum_start_out && tx_data_out == 8'h20 ##1 !sum_start_out)
    else $error("flash-sum command not started");
endmodule
`default_nettype wire

/* File: verilog/brl_pkg.sv */
// Summary of operation
// - Echo sync byte 86H only when rate matches
// - Command receive error replies low nibble 8
// - Receive error reply upper nibble from previous command
// - Unprotected RAM-load command is echoed, load starts
// - Protected RAM-load replies low nibble 6
// - Unknown command replies low nibble 1
// - Twelve password bytes compared against flash
// - Any block receive error replies 18H
// - Block sum plus checksum nonzero replies 11H
// - Password mismatch replies 11H
// - Good block replies normal acknowledge
// - Header block checked and acknowledged before data
// - Data stored consecutively, exactly length bytes
// - Data block checksum verified before final acknowledge
// - Jump only after normal final acknowledge
// - Flash-sum command echoed, summation started
package brl_pkg;
  localparam logic [7:0]  SYNC_BYTE    = 8'h86;
  localparam logic [7:0]  CMD_RAM_LOAD = 8'h10;
  localparam logic [7:0]  CMD_SUM      = 8'h20;
  localparam logic [7:0]  CMD_INFO     = 8'h30;
  localparam logic [7:0]  CMD_ERASE    = 8'h40;
  localparam logic [7:0]  CMD_PROTECT  = 8'h60;
  localparam logic [7:0]  ACK_OK       = 8'h10;
  localparam logic [3:0]  NIB_COMM     = 4'h8;
  localparam logic [3:0]  NIB_PROT     = 4'h6;
  localparam logic [3:0]  NIB_CMD      = 4'h1;
  localparam logic [3:0]  NIB_CKSUM    = 4'h1;
  localparam logic [3:0]  CMD_HI_RST   = 4'h0;
  localparam logic [23:0] PW_FIRST_ADR = 24'h02FEF4;
  localparam logic [23:0] PW_LAST_ADR  = 24'h02FEFF;
  localparam logic [15:0] PW_LEN       = 16'h000C;
  localparam logic [15:0] HDR_LEN      = 16'h0006;
  localparam logic [7:0]  SUM_ZERO     = 8'h00;

  typedef enum logic [9:0] {
    ST_SYNC   = 10'h001,
    ST_CMD    = 10'h002,
    ST_PW     = 10'h004,
    ST_PWCK   = 10'h008,
    ST_HDR    = 10'h010,
    ST_HDRCK  = 10'h020,
    ST_DATA   = 10'h040,
    ST_DATACK = 10'h080,
    ST_SUM    = 10'h100,
    ST_RUN    = 10'h200
  } brl_state_t;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } brl_rx_t;

  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [7:0]  data;
  } brl_ram_wr_t;
endpackage

/* File: verilog/brl_cksum.sv */
`timescale 1ns/1ps
`default_nettype none
module brl_cksum (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       clr_in,
  input  wire logic       add_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       err_in,
  output logic      [7:0] sum_out,
  output logic            err_out
);
  // Modulo-256 running sum of a block
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sum_out <= 8'h00;
    else if (clr_in)
      sum_out <= 8'h00;
    else if (add_in)
      sum_out <= sum_out + byte_in;
  end

  // Sticky receive error of a block
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      err_out <= 1'b0;
    else if (clr_in)
      err_out <= 1'b0;
    else if (add_in && err_in)
      err_out <= 1'b1;
  end
endmodule
`default_nettype wire

/* File: verilog/brl_txhold.sv */
`timescale 1ns/1ps
`default_nettype none
module brl_txhold (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       load_in,
  input  wire logic [7:0] byte_in,
  input  wire logic       tx_ready_in,
  output logic            valid_out,
  output logic      [7:0] data_out
);
  // Reply byte stays offered until the transmitter takes it
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      valid_out <= 1'b0;
    else if (load_in)
      valid_out <= 1'b1;
    else if (tx_ready_in)
      valid_out <= 1'b0;
  end

  // Reply byte value
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      data_out <= 8'h00;
    else if (load_in)
      data_out <= byte_in;
  end
endmodule
`default_nettype wire

/* File: dv/brl_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Boot controller model: feeds received bytes and accepts replies
module brl_ctl_model (
  input  wire logic              sys_clk_in,
  input  wire logic              tx_valid_in,
  input  wire logic [7:0]        tx_data_in,
  output brl_pkg::brl_rx_t       rx_out,
  output logic                   tx_ready_out
);
  int slow_cycles;

  // Quiet link at time zero
  initial
  begin
    rx_out = '0;
    tx_ready_out = 1'b0;
    slow_cycles = 0;
  end

  // One byte per falling edge, so successive calls run back to back
  task automatic put(input logic [7:0] b, input logic e);
    @(negedge sys_clk_in);
    rx_out <= '{1'b1, e, b};
  endtask

  // Released data shows the inverse of the last byte, never a stale copy
  task automatic idle();
    @(negedge sys_clk_in);
    rx_out <= '{1'b0, 1'b0, ~rx_out.data};
  endtask

  // Opening byte of a session
  task automatic sync();
    put(brl_pkg::SYNC_BYTE, 1'b0);
    idle();
  endtask

  // Block plus its checksum; err_at marks one byte as badly received
  task automatic blk(input logic [7:0] b[$], input int err_at, input logic [7:0] adj);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i])
    begin
      s = s + b[i];
      put(b[i], i == err_at);
    end
    put(8'h00 - s + adj, err_at == b.size());
    idle();
  endtask

  // Bounded wait for a reply, optional stall, then one ready pulse
  task automatic take(output logic [7:0] r);
    int n;
    n = 0;
    r = 8'hXX;
    do
    begin
      @(negedge sys_clk_in);
      n++;
    end
    while (tx_valid_in !== 1'b1 && n < 20);
    if (tx_valid_in === 1'b1)
    begin
      r = tx_data_in;
      repeat (slow_cycles) @(negedge sys_clk_in);
      tx_ready_out <= 1'b1;
      @(negedge sys_clk_in);
      tx_ready_out <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/boot_ram_load_protocol_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module boot_ram_load_protocol_tb_top;
  logic                  sys_clk_in;
  logic                  rst_b_in;
  logic                  rate_ok;
  logic                  rd_prot;
  logic                  wr_prot;
  logic                  sum_done;
  logic [95:0]           pw;
  brl_pkg::brl_rx_t      rx;
  logic                  tx_ready;
  logic                  tx_valid;
  logic [7:0]            tx_data;
  brl_pkg::brl_ram_wr_t  ram_wr;
  logic                  jump;
  logic [31:0]           jump_addr;
  logic                  sum_start;
  int                    bad_count;
  int                    num_checks;
  int                    cycles;
  int                    jumps;
  int                    sums;
  logic [31:0]           wa[$];
  logic [7:0]            wd[$];
  logic [7:0]            r;
  logic [7:0]            pw_b[$];
  logic [7:0]            pw_bad[$];
  logic [7:0]            hdr[$];
  logic [7:0]            dat[$];
  localparam logic [31:0] BASE = 32'h000010FE;
  localparam logic [15:0] LEN  = 16'h0004;

  brl_core uut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .rx_in(rx), .rate_ok_in(rate_ok),
    .rd_prot_in(rd_prot), .wr_prot_in(wr_prot), .password_in(pw), .sum_done_in(sum_done),
    .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
    .ram_wr_out(ram_wr), .jump_out(jump), .jump_addr_out(jump_addr), .sum_start_out(sum_start)
  );

  brl_ctl_model ctl (
    .sys_clk_in(sys_clk_in), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
    .rx_out(rx), .tx_ready_out(tx_ready)
  );

  // Clock at 40 MHz
  always #12.5 sys_clk_in = ~sys_clk_in;

  // Records RAM writes, jumps and summation starts mid-cycle; cuts a hang short
  always @(negedge sys_clk_in)
  begin
    if (ram_wr.we === 1'b1)
    begin
      wa.push_back(ram_wr.addr);
      wd.push_back(ram_wr.data);
    end
    if (jump === 1'b1) jumps++;
    if (sum_start === 1'b1) sums++;
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] b, input logic e);
    ctl.put(b, e);
    ctl.idle();
  endtask

  task automatic reply(input logic [7:0] exp);
    ctl.take(r);
    check({24'h0, r}, {24'h0, exp}, "reply");
  endtask

  // No reply may appear for ten cycles
  task automatic silent();
    int k;
    k = 0;
    repeat (10)
    begin
      @(negedge sys_clk_in);
      if (tx_valid !== 1'b0) k++;
    end
    check(k, 0, "unexpected reply");
  endtask

  // Command wait must be back: a known command is echoed
  task automatic fresh();
    cmd(8'h30, 1'b0);
    reply(8'h30);
  endtask

  task automatic enter();
    cmd(brl_pkg::CMD_RAM_LOAD, 1'b0);
    reply(8'h10);
  endtask

  task automatic t_sync();
    ctl.sync();
    silent();
    rate_ok = 1'b1;
    ctl.sync();
    reply(brl_pkg::SYNC_BYTE);
  endtask

  task automatic t_cmd();
    logic [7:0] ok[3];
    ok = '{8'h30, 8'h40, 8'h60};
    cmd(8'h5A, 1'b0);
    ctl.take(r);
    check(r[3:0], 4'h1, "unknown command");
    cmd(8'h55, 1'b0);
    reply(8'h51);
    cmd(8'hA3, 1'b1);
    reply(8'h58);
    foreach (ok[i])
    begin
      cmd(ok[i], 1'b0);
      reply(ok[i]);
    end
    cmd(brl_pkg::CMD_SUM, 1'b0);
    reply(8'h20);
    check(sums, 1, "summation start");
    cmd(8'h30, 1'b0);
    silent();
    sum_done = 1'b1;
    @(negedge sys_clk_in);
    sum_done = 1'b0;
    fresh();
  endtask

  task automatic t_prot();
    rd_prot = 1'b1;
    cmd(8'h10, 1'b0);
    ctl.take(r);
    check(r[3:0], 4'h6, "protected load");
    cmd(8'h10, 1'b0);
    reply(8'h16);
    rd_prot = 1'b0;
    wr_prot = 1'b1;
    cmd(8'h10, 1'b0);
    reply(8'h16);
    wr_prot = 1'b0;
    fresh();
  endtask

  task automatic t_pw();
    enter();
    ctl.blk(pw_b, -1, 8'h01);
    reply(8'h11);
    fresh();
    enter();
    ctl.blk(pw_bad, -1, 8'h00);
    reply(8'h11);
    fresh();
    enter();
    ctl.blk(pw_b, 5, 8'h01);
    reply(8'h18);
    fresh();
    enter();
    ctl.blk(pw_b, 12, 8'h00);
    reply(8'h18);
    fresh();
  endtask

  task automatic t_hdr();
    enter();
    ctl.blk(pw_b, -1, 8'h00);
    reply(8'h10);
    ctl.blk(hdr, -1, 8'h01);
    reply(8'h11);
    fresh();
    enter();
    ctl.slow_cycles = 3;
    ctl.blk(pw_b, -1, 8'h00);
    reply(8'h10);
    ctl.blk(hdr, 2, 8'h00);
    reply(8'h18);
    ctl.slow_cycles = 0;
    fresh();
  endtask

  task automatic t_data(input logic [7:0] adj);
    wa.delete();
    wd.delete();
    enter();
    ctl.blk(pw_b, -1, 8'h00);
    reply(8'h10);
    ctl.blk(hdr, -1, 8'h00);
    reply(8'h10);
    ctl.blk(dat, -1, adj);
    reply(adj == 8'h00 ? 8'h10 : 8'h11);
  endtask

  task automatic t_load();
    t_data(8'h01);
    check(jumps, 0, "jump after bad block");
    fresh();
    t_data(8'h00);
    check(jumps, 1, "jump count");
    check(jump_addr, BASE, "jump address");
    check(wa.size(), 4, "write count");
    foreach (wa[i])
    begin
      check(wa[i], BASE + i, "write address");
      check(wd[i], dat[i], "write data");
    end
    cmd(8'h30, 1'b0);
    silent();
  endtask

  // Mid-run reset, then an empty data block whose checksum is badly received
  task automatic t_reset();
    logic [7:0] nodata[$];
    rst_b_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    @(negedge sys_clk_in);
    check(tx_valid, 0, "reply offered after reset");
    check(jump_addr, 0, "jump address after reset");
    ctl.sync();
    reply(brl_pkg::SYNC_BYTE);
    enter();
    ctl.blk(pw_b, -1, 8'h00);
    reply(8'h10);
    hdr[4] = 8'h00;
    hdr[5] = 8'h00;
    ctl.blk(hdr, -1, 8'h00);
    reply(8'h10);
    ctl.blk(nodata, 0, 8'h00);
    reply(8'h18);
    check(jumps, 1, "jump after bad empty block");
    fresh();
  endtask

  // Stimulus: password 0A0H + k, load header and data from the constants
  initial
  begin
    sys_clk_in = 1'b0;
    rst_b_in = 1'b0;
    rate_ok = 1'b0;
    rd_prot = 1'b0;
    wr_prot = 1'b0;
    sum_done = 1'b0;
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    jumps = 0;
    sums = 0;
    for (int k = 0; k < 12; k++)
    begin
      pw[8*k +: 8] = 8'hA0 + k;
      pw_b.push_back(8'hA0 + k);
    end
    pw_bad = pw_b;
    pw_bad[11] = pw_bad[11] ^ 8'h01;
    hdr = {BASE[31:24], BASE[23:16], BASE[15:8], BASE[7:0]};
    hdr.push_back(LEN[15:8]);
    hdr.push_back(LEN[7:0]);
    dat = {8'hC3, 8'h5A, 8'h00, 8'hFF};
    repeat (8) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    t_sync();
    t_cmd();
    t_prot();
    t_pw();
    t_hdr();
    t_load();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
